// File: common/pis_pkg.sv
// How it works
// - up to 62 request sources feed the block, priority fixed by wiring
// - interrupt only if top request beats running level and enable is set
// - sources land on 48 interrupt register positions; position sets level
// - one position is a common line shared by 15 sources, one level
// - a set common mask bit blocks its source; clear bit lets it request
// - the mask loads at any time and acts on the next evaluation
// - request lines of fitted positions are sampled each cycle into the interrupt register
// - encoder gives top level; comparator flags it when above current level
// - stacking starts only after the running instruction has completed
// - stacking pushes next-instruction address and status word to memory
// - stack pointer decrements per push to point at next free word
// - accepted 6-bit level is loaded into current_priority_register
// - level indexes a vector word; its content becomes the new address
// - an enable instruction re-opens acceptance, allowing nesting
// - return_from_interrupt pops status word and address from the stack
// - on return the status level field reloads the priority register
// - eight base levels, level modules extend the count to 48
// - interval timer raises a request every 20 ms
// - control_io_instruction starts and stops the timer; stopped means quiet
// - crystal timer period selectable as 1, 2, 5 or 10 ms
package pis_pkg;
  localparam int NPOS = 48;
  localparam int LVLW = 6;
  localparam int NCMN = 15;
  localparam int AW = 16;
  localparam int DW = 16;
  localparam int NMOD = 3;
  localparam int BASE_LEVELS = 8;
  localparam int MOD1_TOP = 18;
  localparam int MOD2_TOP = 28;
  localparam int MOD3_TOP = 48;
  localparam int COMMON_POS = 0;
  localparam int RTC_POS = 1;
  localparam int XTAL_POS = 8;
  localparam int PSW_PL_LSB = 0;
  localparam logic [AW-1:0] VEC_BASE = 16'h0000;
  localparam logic [AW-1:0] SP_RESET = 16'h0000;
  localparam logic [LVLW-1:0] PL_LOWEST = 6'h00;
  localparam logic [1:0] XSEL_1MS = 2'h0;
  localparam logic [1:0] XSEL_2MS = 2'h1;
  localparam logic [1:0] XSEL_5MS = 2'h2;
  localparam int CLK_MHZ = 100;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int RTC_MS = 20;
  localparam int XTAL_MS_1 = 1;
  localparam int XTAL_MS_2 = 2;
  localparam int XTAL_MS_5 = 5;
  localparam int XTAL_MS_10 = 10;
  localparam int RTC_CYCLES = RTC_MS * CYC_PER_MS;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_WAIT = 7'h02,
    ST_PUSHP = 7'h04,
    ST_PUSHS = 7'h08,
    ST_VEC = 7'h10,
    ST_POPS = 7'h20,
    ST_POPP = 7'h40
  } pis_state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } pis_mem_t;

  typedef struct packed {
    pis_state_t st;
    logic [NPOS-1:0] reqS1;
    logic [NPOS-1:0] reqS2;
    logic [NCMN-1:0] cmnS1;
    logic [NCMN-1:0] cmnS2;
    logic [NPOS-1:0] intReg;
    logic [NCMN-1:0] cmnMask;
    logic [LVLW-1:0] pl;
    logic en;
    logic [AW-1:0] sp;
    logic [LVLW-1:0] lvl;
    logic [31:0] rtcCnt;
    logic rtcOn;
    logic rtcReq;
    logic [31:0] xtalCnt;
    logic xtalOn;
    logic [1:0] xtalSel;
    logic xtalReq;
    pis_mem_t mem;
    logic [AW-1:0] newP;
    logic loadP;
    logic [DW-1:0] pswOut;
    logic loadPsw;
  } pis_regs_t;
endpackage

// File: tb/pis_mem_model.sv
`timescale 1ns/1ns
module pis_mem_model
  import pis_pkg::*;
(
  // clock and request
  input wire logic clk,
  input pis_mem_t memOut,
  input wire logic slow,
  // answer
  output logic memAck,
  output logic [DW-1:0] memRdata
);
  logic [DW-1:0] store [256];
  logic [1:0] waitCnt;
  logic [DW-1:0] lastRd;
  initial
  begin
    for (int i = 0; i < 256; i++)
      store[i] = 16'h4000 + 16'(i);
    waitCnt = 2'h0;
    lastRd = 16'h0000;
  end
  // data only valid with ack; otherwise the bus shows junk
  always_comb
  begin
    memAck = memOut.req && (!slow || waitCnt == 2'h2);
    memRdata = memAck ? store[memOut.addr[7:0]] : ~lastRd;
  end
  always @(posedge clk)
  begin
    if (memAck)
    begin
      waitCnt <= 2'h0;
      lastRd <= memRdata;
      if (memOut.we)
        store[memOut.addr[7:0]] <= memOut.wdata;
    end
    else if (memOut.req)
      waitCnt <= waitCnt + 2'h1;
  end
endmodule // pis_mem_model

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench
  import pis_pkg::*;
;
  logic clk, sys_rst, maskLoad, instrDone, intrEnable, rtnExec, spWrite;
  logic rtcStart, rtcStop, xtalStart, xtalStop, memAck, slow;
  logic clkEn, intrDisable;
  logic [NPOS-1:0] reqPins;
  logic [NCMN-1:0] commonPins, maskData;
  logic [NMOD-1:0] levelModules;
  logic [AW-1:0] pAddr, spData, newPAddr, stackPtr;
  logic [DW-1:0] pswIn, memRdata, restoredPsw;
  logic [1:0] xtalSelIn;
  logic [LVLW-1:0] curPriority;
  logic loadPAddr, loadPswOut, intrEnabled, intPending, stackBusy;
  pis_mem_t memOut;
  int err_total = 0;
  int comparisons = 0;

  pis_ctrl #(.RTC_PERIOD(20), .XTAL_MS_CYC(4)) pis_ctrl_inst (
    .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .reqPins(reqPins),
    .commonPins(commonPins), .maskLoad(maskLoad), .maskData(maskData),
    .levelModules(levelModules), .instrDone(instrDone),
    .intrEnable(intrEnable), .intrDisable(intrDisable), .rtnExec(rtnExec),
    .pAddr(pAddr), .pswIn(pswIn), .spWrite(spWrite), .spData(spData),
    .rtcStart(rtcStart), .rtcStop(rtcStop), .xtalStart(xtalStart),
    .xtalStop(xtalStop), .xtalSelIn(xtalSelIn), .memOut(memOut),
    .memAck(memAck), .memRdata(memRdata), .newPAddr(newPAddr),
    .loadPAddr(loadPAddr), .restoredPsw(restoredPsw),
    .loadPswOut(loadPswOut), .curPriority(curPriority),
    .intrEnabled(intrEnabled), .stackPtr(stackPtr),
    .intPending(intPending), .stackBusy(stackBusy)
  );
  pis_mem_model pis_mem_model_inst (
    .clk(clk), .memOut(memOut), .slow(slow), .memAck(memAck),
    .memRdata(memRdata)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic chk(logic ok, string m);
    comparisons++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic chkv(logic [15:0] got, logic [15:0] exp, string m);
    chk(got === exp, m);
  endtask
  task automatic waitPend(int lim, output int n);
    n = 0;
    while (intPending !== 1'b1 && n < lim)
    begin
      tick(1);
      n++;
    end
    chk(intPending === 1'b1, "no pending");
  endtask
  task automatic waitLoad();
    int i;
    i = 0;
    while (loadPAddr !== 1'b1 && i < 40)
    begin
      tick(1);
      i++;
    end
    chk(loadPAddr === 1'b1, "no load");
  endtask
  task automatic enter(logic [15:0] pa, logic [5:0] lvl);
    logic [5:0] oldPl;
    logic [15:0] sp0;
    oldPl = curPriority;
    sp0 = stackPtr;
    pAddr = pa;
    pulse(instrDone);
    waitLoad();
    chkv(newPAddr, 16'h4000 + 16'(lvl), "vector");
    chkv(16'(curPriority), 16'(lvl), "level");
    chkv(stackPtr, sp0 - 16'h0002, "sp");
    chkv(pis_mem_model_inst.store[sp0[7:0]], pa, "pushed pc");
    chkv(pis_mem_model_inst.store[sp0[7:0] - 8'h01],
      {pswIn[15:6], oldPl}, "pushed psw");
  endtask
  task automatic leave(logic [15:0] pa, logic [5:0] lvl);
    logic [15:0] sp0;
    sp0 = stackPtr;
    pulse(rtnExec);
    waitLoad();
    chk(loadPswOut === 1'b1, "psw load");
    chkv(restoredPsw, {pswIn[15:6], lvl}, "psw");
    chkv(newPAddr, pa, "return pc");
    chkv(16'(curPriority), 16'(lvl), "return level");
    chkv(stackPtr, sp0 + 16'h0002, "return sp");
  endtask

  task automatic t_first();
    int n;
    chkv(16'(curPriority), 16'h0000, "reset level");
    chk(intrEnabled === 1'b0, "reset enable");
    spData = 16'h0080;
    // load held across a frozen edge, then one live edge
    clkEn = 1'b0;
    spWrite = 1'b1;
    tick(1);
    chkv(stackPtr, SP_RESET, "frozen sp");
    clkEn = 1'b1;
    tick(1);
    spWrite = 1'b0;
    chkv(stackPtr, 16'h0080, "sp load");
    reqPins[5] = 1'b1;
    tick(8);
    chk(intPending === 1'b0, "disabled taken");
    pulse(intrEnable);
    waitPend(4, n);
    tick(5);
    chk(stackBusy === 1'b0, "early stacking");
    chk(intPending === 1'b1, "pending lost");
    enter(16'h1234, 6'h06);
  endtask
  task automatic t_nest();
    int n;
    pulse(intrEnable);
    reqPins[20] = 1'b1;
    tick(8);
    chk(intPending === 1'b0, "equal or unfitted");
    reqPins[10] = 1'b1;
    waitPend(8, n);
    chk(n >= 4 && n <= 5, "sample delay");
    slow = 1'b1;
    enter(16'h2345, 6'h0b);
    slow = 1'b0;
    reqPins = '0;
    leave(16'h2345, 6'h06);
    leave(16'h1234, 6'h00);
  endtask
  task automatic t_common();
    int n;
    pulse(intrEnable);
    pulse(intrDisable);
    chk(intrEnabled === 1'b0, "disable ignored");
    pulse(intrEnable);
    maskData = 15'h0008;
    pulse(maskLoad);
    commonPins = 15'h0008;
    tick(8);
    chk(intPending === 1'b0, "masked source");
    maskData = 15'h0000;
    pulse(maskLoad);
    waitPend(8, n);
    enter(16'h0500, 6'h01);
    commonPins = 15'h0000;
    leave(16'h0500, 6'h00);
  endtask
  task automatic t_rtc();
    int n;
    pulse(intrEnable);
    pulse(rtcStart);
    waitPend(40, n);
    chk(n >= 18 && n <= 26, "rtc period");
    pulse(rtcStop);
    enter(16'h0300, 6'h02);
    leave(16'h0300, 6'h00);
    pulse(intrEnable);
    tick(60);
    chk(intPending === 1'b0, "rtc stopped");
  endtask
  task automatic t_xtal();
    int n;
    int ms[4] = '{1, 2, 5, 10};
    for (int s = 0; s < 4; s++)
    begin
      xtalSelIn = 2'(s);
      pulse(intrEnable);
      pulse(xtalStart);
      waitPend(60, n);
      chk(n >= 4 * ms[s] - 2 && n <= 4 * ms[s] + 6, "xtal period");
      pulse(xtalStop);
      enter(16'h0400, 6'h09);
      leave(16'h0400, 6'h00);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    sys_rst = 1'b1;
    {maskLoad, instrDone, intrEnable, rtnExec, spWrite} = '0;
    {rtcStart, rtcStop, xtalStart, xtalStop, slow} = '0;
    clkEn = 1'b1;
    intrDisable = 1'b0;
    reqPins = '0;
    commonPins = '0;
    maskData = '0;
    levelModules = 3'h1;
    pAddr = '0;
    spData = '0;
    pswIn = 16'ha5c0;
    xtalSelIn = 2'h0;
    tick(2);
    sys_rst = 1'b0;
    t_first();
    t_nest();
    t_common();
    t_rtc();
    t_xtal();
    wrap_up();
  end
  // long stall guard, far beyond the few hundred cycles of the run
  initial
  begin
    #100000;
    err_total++;
    wrap_up();
  end
endmodule // testbench

// File: verilog/pis_ctrl.sv
`timescale 1ns/1ns
module pis_ctrl
  import pis_pkg::*;
#(
  parameter int unsigned RTC_PERIOD = RTC_CYCLES,
  parameter int unsigned XTAL_MS_CYC = CYC_PER_MS
)
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // request pins and common line
  input wire logic [NPOS-1:0] reqPins,
  input wire logic [NCMN-1:0] commonPins,
  input wire logic maskLoad,
  input wire logic [NCMN-1:0] maskData,
  // fitted level modules
  input wire logic [NMOD-1:0] levelModules,
  // instruction sequencer
  input wire logic instrDone,
  input wire logic intrEnable,
  input wire logic intrDisable,
  input wire logic rtnExec,
  input wire logic [AW-1:0] pAddr,
  input wire logic [DW-1:0] pswIn,
  input wire logic spWrite,
  input wire logic [AW-1:0] spData,
  // control_io_instruction timer commands
  input wire logic rtcStart,
  input wire logic rtcStop,
  input wire logic xtalStart,
  input wire logic xtalStop,
  input wire logic [1:0] xtalSelIn,
  // memory port
  output pis_mem_t memOut,
  input wire logic memAck,
  input wire logic [DW-1:0] memRdata,
  // results to sequencer
  output logic [AW-1:0] newPAddr,
  output logic loadPAddr,
  output logic [DW-1:0] restoredPsw,
  output logic loadPswOut,
  output logic [LVLW-1:0] curPriority,
  output logic intrEnabled,
  output logic [AW-1:0] stackPtr,
  output logic intPending,
  output logic stackBusy
);

  pis_regs_t q;
  pis_regs_t d;
  logic [LVLW-1:0] encLvl;
  logic takeIrq;

  function automatic logic [LVLW-1:0] hiLevel(input logic [NPOS-1:0] v);
    logic [LVLW-1:0] r;
    r = PL_LOWEST;
    for (int i = 0; i < NPOS; i++)
    begin
      if (v[i])
      begin
        r = LVLW'(i + 1);
      end
    end
    return r;
  endfunction

  // positions present for the fitted modules
  function automatic logic [NPOS-1:0] fitted(input logic [NMOD-1:0] m);
    logic [NPOS-1:0] f;
    f = '0;
    f[BASE_LEVELS-1:0] = '1;
    f[MOD1_TOP-1:BASE_LEVELS] = {(MOD1_TOP - BASE_LEVELS){m[0]}};
    f[MOD2_TOP-1:MOD1_TOP] = {(MOD2_TOP - MOD1_TOP){m[1]}};
    f[MOD3_TOP-1:MOD2_TOP] = {(MOD3_TOP - MOD2_TOP){m[2]}};
    return f;
  endfunction

  function automatic logic [31:0] xtalPeriod(input logic [1:0] s);
    int unsigned ms;
    case (s)
      XSEL_1MS: ms = XTAL_MS_1;
      XSEL_2MS: ms = XTAL_MS_2;
      XSEL_5MS: ms = XTAL_MS_5;
      default: ms = XTAL_MS_10;
    endcase
    return 32'(ms * XTAL_MS_CYC);
  endfunction

  assign encLvl = hiLevel(q.intReg);
  assign takeIrq = q.en && (encLvl > q.pl);

  always_comb
  begin
    logic [NPOS-1:0] smp;
    smp = '0;
    d = q;
    d.loadP = 1'b0;
    d.loadPsw = 1'b0;
    // two-stage synchronisers on pins
    d.reqS1 = reqPins;
    d.reqS2 = q.reqS1;
    d.cmnS1 = commonPins;
    d.cmnS2 = q.cmnS1;
    // interrupt register, loaded every cycle
    smp = q.reqS2;
    smp[COMMON_POS] = |(q.cmnS2 & ~q.cmnMask);
    smp[RTC_POS] = q.rtcReq;
    smp[XTAL_POS] = q.xtalReq;
    d.intReg = smp & fitted(levelModules);
    if (maskLoad)
    begin
      d.cmnMask = maskData;
    end

    // flag drops once its level is taken; a period end below still wins
    if (q.st == ST_PUSHS && memAck)
    begin
      d.rtcReq = q.rtcReq && (q.lvl != LVLW'(RTC_POS + 1));
      d.xtalReq = q.xtalReq && (q.lvl != LVLW'(XTAL_POS + 1));
    end
    // mains-period timer
    if (q.rtcOn)
    begin
      if (q.rtcCnt >= RTC_PERIOD - 1)
      begin
        d.rtcCnt = '0;
        d.rtcReq = 1'b1;
      end
      else
      begin
        d.rtcCnt = q.rtcCnt + 32'h00000001;
      end
    end
    if (rtcStart)
    begin
      d.rtcOn = 1'b1;
      d.rtcCnt = '0;
    end
    if (rtcStop)
    begin
      d.rtcOn = 1'b0;
    end

    // crystal timer
    if (q.xtalOn)
    begin
      if (q.xtalCnt >= xtalPeriod(q.xtalSel) - 32'h00000001)
      begin
        d.xtalCnt = '0;
        d.xtalReq = 1'b1;
      end
      else
      begin
        d.xtalCnt = q.xtalCnt + 32'h00000001;
      end
    end
    if (xtalStart)
    begin
      d.xtalOn = 1'b1;
      d.xtalSel = xtalSelIn;
      d.xtalCnt = '0;
    end
    if (xtalStop)
    begin
      d.xtalOn = 1'b0;
    end

    case (q.st)
      ST_IDLE:
      begin
        if (rtnExec)
        begin
          d.st = ST_POPS;
          d.mem.req = 1'b1;
          d.mem.we = 1'b0;
          d.mem.addr = q.sp + 16'h0001;
        end
        else if (takeIrq)
        begin
          d.st = ST_WAIT;
        end
        else if (spWrite)
        begin
          d.sp = spData;
        end
      end
      ST_WAIT:
      begin
        // a return in flight takes precedence over a new entry
        if (rtnExec)
        begin
          d.st = ST_POPS;
          d.mem.req = 1'b1;
          d.mem.we = 1'b0;
          d.mem.addr = q.sp + 16'h0001;
        end
        else if (instrDone)
        begin
          if (takeIrq)
          begin
            d.st = ST_PUSHP;
            d.lvl = encLvl;
            d.mem.req = 1'b1;
            d.mem.we = 1'b1;
            d.mem.addr = q.sp;
            d.mem.wdata = pAddr;
          end
          else
          begin
            // request vanished before the boundary
            d.st = ST_IDLE;
          end
        end
      end
      ST_PUSHP:
      begin
        if (memAck)
        begin
          d.st = ST_PUSHS;
          d.sp = q.sp - 16'h0001;
          d.mem.addr = q.sp - 16'h0001;
          d.mem.wdata = pswIn;
          d.mem.wdata[PSW_PL_LSB +: LVLW] = q.pl;
        end
      end
      ST_PUSHS:
      begin
        if (memAck)
        begin
          d.st = ST_VEC;
          d.sp = q.sp - 16'h0001;
          d.pl = q.lvl;
          d.en = 1'b0;
          d.mem.we = 1'b0;
          d.mem.addr = VEC_BASE + AW'(q.lvl);
        end
      end
      ST_VEC:
      begin
        if (memAck)
        begin
          d.st = ST_IDLE;
          d.mem.req = 1'b0;
          d.newP = memRdata;
          d.loadP = 1'b1;
        end
      end
      ST_POPS:
      begin
        if (memAck)
        begin
          d.st = ST_POPP;
          d.pswOut = memRdata;
          d.sp = q.sp + 16'h0001;
          d.mem.addr = q.sp + 16'h0002;
        end
      end
      ST_POPP:
      begin
        if (memAck)
        begin
          d.st = ST_IDLE;
          d.sp = q.sp + 16'h0001;
          d.mem.req = 1'b0;
          d.newP = memRdata;
          d.loadP = 1'b1;
          d.loadPsw = 1'b1;
          d.pl = q.pswOut[PSW_PL_LSB +: LVLW];
        end
      end
      default:
      begin
        d.st = ST_IDLE;
        d.mem.req = 1'b0;
      end
    endcase

    if (intrDisable)
    begin
      d.en = 1'b0;
    end
    if (intrEnable)
    begin
      d.en = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.pl <= PL_LOWEST;
      q.en <= 1'b0;
      q.sp <= SP_RESET;
    end
    else if (clkEn)
    begin
      q <= d;
    end
  end

  assign memOut = q.mem;
  assign newPAddr = q.newP;
  assign loadPAddr = q.loadP;
  assign restoredPsw = q.pswOut;
  assign loadPswOut = q.loadPsw;
  assign curPriority = q.pl;
  assign intrEnabled = q.en;
  assign stackPtr = q.sp;
  assign intPending = (q.st == ST_WAIT);
  assign stackBusy = (q.st != ST_IDLE) && (q.st != ST_WAIT);

  a_reset_lowest: assert property (@(posedge clk)
    sys_rst |=> (q.pl == PL_LOWEST) && !q.en)
    else $error("reset left level or enable set");
  a_no_entry_low: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && q.st == ST_IDLE && !rtnExec && (!q.en || encLvl <= q.pl))
    |=> q.st != ST_WAIT)
    else $error("entry without higher enabled request");
  a_wait_boundary: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && q.st == ST_WAIT && !instrDone && !rtnExec) |=> q.st == ST_WAIT)
    else $error("stacking began before instruction end");
  a_push_addr: assert property (@(posedge clk) disable iff (sys_rst)
    (q.st == ST_PUSHP) |-> q.mem.req && q.mem.we && q.mem.addr == q.sp)
    else $error("address push not at stack pointer");
  a_sp_decrement: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && q.st == ST_PUSHP && memAck)
    |=> q.sp == $past(q.sp) - 16'h0001 ##0 q.st == ST_PUSHS)
    else $error("stack pointer not decremented");
  a_level_load: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && q.st == ST_PUSHS && memAck)
    |=> q.pl == $past(q.lvl) && !q.en && q.mem.addr == VEC_BASE + AW'(q.lvl))
    else $error("accepted level not loaded");
  a_vector_fetch: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && q.st == ST_VEC && memAck)
    |=> q.loadP && q.newP == $past(memRdata) ##1 !q.loadP || !clkEn)
    else $error("vector not delivered");
  a_return_level: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && q.st == ST_POPP && memAck)
    |=> q.pl == $past(q.pswOut[PSW_PL_LSB +: LVLW]) && q.loadPsw)
    else $error("return level not restored");
  a_mask_load: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && maskLoad) |=> q.cmnMask == $past(maskData))
    else $error("mask not loaded");
  a_common_masked: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && (q.cmnS2 & ~q.cmnMask) == '0) |=> !q.intReg[COMMON_POS])
    else $error("masked common source requested");
  a_enable_instr: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && intrEnable) |=> q.en)
    else $error("enable instruction ignored");
  a_timer_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && !q.rtcOn && !rtcStart) |=> q.rtcReq <= $past(q.rtcReq))
    else $error("stopped timer raised a request");

endmodule // pis_ctrl
